// ---- utxc_cfg.svh ----
// Offsets, field positions, reset values and codes of the transmit endpoint.
// Assumes inclusion by bare name from the package, the checker and the bench.
`ifndef UTXC_CFG_SVH
`define UTXC_CFG_SVH

// Register indices; the byte address is four times the index
`define UTXC_IDX_TXD      32'h50001852
`define UTXC_IDX_TXS      32'h50001854
`define UTXC_IDX_TXC      32'h50001856
`define UTXC_IDX_EPC      32'h50001858
`define UTXC_IDX_FIFO_WARNING_EVENT_REGISTER     32'h50001860

// Control register fields
`define UTXC_TXC_IGN      7
`define UTXC_TXC_WLH      6
`define UTXC_TXC_WLL      5
`define UTXC_TXC_RFF      4
`define UTXC_TXC_FLUSH    3
`define UTXC_TXC_TOGGLE   2
`define UTXC_TXC_LAST     1
`define UTXC_TXC_ARM      0
`define UTXC_TXC_RESET    8'h00

// Endpoint configuration fields
`define UTXC_EPC_STALL    7
`define UTXC_EPC_ISO      5
`define UTXC_EPC_RESET    8'h00

// Status and event fields
`define UTXC_TXS_URUN     7
`define UTXC_TXS_DONE     5
`define UTXC_FIFO_WARNING_EVENT_REGISTER_WARN    0

// Warning thresholds, in bytes
`define UTXC_WARN_LIM1    7'h05
`define UTXC_WARN_LIM2    7'h09
`define UTXC_WARN_LIM3    7'h11

// Packet identifiers
`define UTXC_PID_DATA0    8'hc3
`define UTXC_PID_DATA1    8'h4b
`define UTXC_PID_NAK      8'h5a
`define UTXC_PID_STALL    8'h1e

`define UTXC_CRC_INIT     16'hffff
`define UTXC_CRC_POLY     16'ha001
`define UTXC_EMPTY_CAP    7'h1f

`endif

// ---- utxc_pkg.sv ----
// Types shared by the transmit endpoint modules.
// Assumes utxc_cfg.svh is on the include path.
`include "utxc_cfg.svh"

package utxc_pkg;
	localparam int FIFO_AW = 6;
	typedef logic [FIFO_AW:0]   utxc_ptr_t;
	typedef logic [FIFO_AW-1:0] utxc_addr_t;
	typedef logic [7:0]         utxc_byte_t;
	typedef enum logic [2:0] {
		UTXC_IDLE,
		UTXC_HSK,
		UTXC_PID,
		UTXC_DATA,
		UTXC_CRC_LO,
		UTXC_CRC_HI,
		UTXC_ABORT
	} utxc_state_t;
endpackage

// ---- utxc_fifo_mem.sv ----
// Transmit FIFO storage: one write port, registered read data.
// Assumes the caller never writes while full.
`timescale 1ns/1ns

module utxc_fifo_mem
	import utxc_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             wr_en,
	input  wire utxc_pkg::utxc_addr_t wr_addr,
	input  wire utxc_pkg::utxc_byte_t wr_data,
	input  wire utxc_pkg::utxc_addr_t rd_addr,
	output utxc_pkg::utxc_byte_t      rd_data_ff
);
	utxc_byte_t mem [0:(1<<FIFO_AW)-1];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		rd_data_ff <= mem[rd_addr];
	end
endmodule

// ---- utxc_crc16.sv ----
// CRC16 over payload bytes, least significant bit first.
// Assumes clear and update are never asked in the same cycle.
`timescale 1ns/1ns

module utxc_crc16
	import utxc_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic             clear,
	input  wire logic             update,
	input  wire utxc_pkg::utxc_byte_t data,
	output logic [15:0]           crc_ff
);
	logic [15:0] nxt_crc;

	always_comb begin
		nxt_crc = crc_ff;
		for (int i = 0; i < 8; i++) begin
			if (nxt_crc[0] ^ data[i]) begin
				nxt_crc = (nxt_crc >> 1) ^ `UTXC_CRC_POLY;
			end else begin
				nxt_crc = nxt_crc >> 1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n || clear) begin
			crc_ff <= `UTXC_CRC_INIT;
		end else if (update) begin
			crc_ff <= nxt_crc;
		end
	end
endmodule

// ---- utxc_tx_endpoint.sv ----
// Transmit endpoint control: FIFO, arm, packet end, refill, flush, PID.
// Assumes an APB master and a same-clock serial engine taking tx bytes.
//
// Overview of operation
// - Limit code 00 off; 5, 9, 17 bytes
// - Set warning flag when queue below limit
// - Warning flag raised only while armed
// - Packet-complete write saves read pointer
// - Refill restores read pointer from save
// - Refill waits for transmission end, self-clears
// - Flush empties FIFO, disarms, resets pointers
// - Flush waits for transmission end, self-clears
// - Non-isochronous toggle picks DATA0 or DATA1
// - Isochronous send only when frame parity matches or the ignore bit is set
// - Isochronous unsent data flushed at next SOF
// - Isochronous packets always use DATA0
// - Empty without packet-complete forces stuff error
// - Packet-complete with no data sends empty packet
// - Payload, CRC16, EOP, then clear packet-complete
// - Arm cleared after packet or STALL
// - Isochronous when configuration bit is set
// - Underrun status set, cleared by reading
`timescale 1ns/1ns

module utxc_tx_endpoint
	import utxc_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [31:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             in_token,
	input  wire logic             sof_seen,
	input  wire logic             frame_number_lsb,
	input  wire logic             tx_ready,
	output logic                  tx_valid,
	output utxc_pkg::utxc_byte_t  tx_data,
	output logic                  tx_eop,
	output logic                  tx_stuff_err
);
	import utxc_pkg::*;

	utxc_state_t state_ff;
	utxc_state_t nxt_state;
	logic [7:0]  txc_ff;
	logic [7:0]  epc_ff;
	utxc_ptr_t   wr_ptr_ff;
	utxc_ptr_t   rd_ptr_ff;
	utxc_ptr_t   save_ptr_ff;
	utxc_ptr_t   count;
	utxc_ptr_t   warn_lim;
	utxc_byte_t  hsk_pid_ff;
	utxc_byte_t  fifo_q;
	logic [15:0] crc;
	logic [31:0] prdata_ff;
	logic        data_rdy_ff;
	logic        warn_ev_ff;
	logic        urun_ff;
	logic        done_ff;
	logic        iso_seen_ff;

	logic        apb_acc;
	logic        apb_wr;
	logic        apb_rd;
	logic        hit_txd;
	logic        hit_txs;
	logic        hit_txc;
	logic        hit_epc;
	logic        hit_fifo_warning_event_register;
	logic        is_iso;
	logic        armed;
	logic        send_ok;
	logic        fifo_full;
	logic        push;
	logic        advance;
	logic        idle;
	logic        pkt_end;
	logic        stall_sent;
	logic        do_refill;
	logic        do_flush;
	logic        iso_drop;
	logic        warn_now;
	logic        urun_set;

	// APB decode; every access completes without wait states
	assign apb_acc  = psel && penable;
	assign apb_wr   = apb_acc && pwrite;
	// Read-to-clear acts at the capture edge, so no event slips between
	assign apb_rd   = psel && !penable && !pwrite;
	// Index keeps its low 30 bits, as the byte address does
	assign hit_txd  = paddr[31:2] == 30'(`UTXC_IDX_TXD);
	assign hit_txs  = paddr[31:2] == 30'(`UTXC_IDX_TXS);
	assign hit_txc  = paddr[31:2] == 30'(`UTXC_IDX_TXC);
	assign hit_epc  = paddr[31:2] == 30'(`UTXC_IDX_EPC);
	assign hit_fifo_warning_event_register = paddr[31:2] == 30'(`UTXC_IDX_FIFO_WARNING_EVENT_REGISTER);
	assign pready   = 1'b1;
	assign pslverr  = apb_acc && !(hit_txd || hit_txs || hit_txc
		|| hit_epc || hit_fifo_warning_event_register);
	assign prdata   = prdata_ff;

	assign is_iso = epc_ff[`UTXC_EPC_ISO];
	assign armed  = txc_ff[`UTXC_TXC_ARM];
	// In isochronous mode frame parity gates the arm bit unless the ignore bit is set
	assign send_ok = armed && (!is_iso || txc_ff[`UTXC_TXC_IGN]
		|| frame_number_lsb == txc_ff[`UTXC_TXC_TOGGLE]);

	assign count     = wr_ptr_ff - rd_ptr_ff;
	assign fifo_full = count[FIFO_AW];
	assign push      = apb_wr && hit_txd && !fifo_full;
	assign idle      = state_ff == UTXC_IDLE;
	assign advance   = state_ff == UTXC_DATA && data_rdy_ff && tx_ready;
	assign pkt_end   = state_ff == UTXC_CRC_HI && tx_ready;
	assign stall_sent = state_ff == UTXC_HSK && tx_ready
		&& hsk_pid_ff == `UTXC_PID_STALL;

	// Pointer moves only while no packet is on the wire
	assign do_refill = idle && txc_ff[`UTXC_TXC_RFF];
	assign do_flush  = idle && txc_ff[`UTXC_TXC_FLUSH];
	// Armed in a matching frame but no token came
	assign iso_drop  = idle && sof_seen && is_iso && iso_seen_ff;

	always_comb begin
		case (txc_ff[`UTXC_TXC_WLH:`UTXC_TXC_WLL])
			2'b01:   warn_lim = `UTXC_WARN_LIM1;
			2'b10:   warn_lim = `UTXC_WARN_LIM2;
			2'b11:   warn_lim = `UTXC_WARN_LIM3;
			default: warn_lim = '0;
		endcase
	end

	assign warn_now = armed && count < warn_lim;
	assign urun_set = state_ff == UTXC_DATA && !data_rdy_ff && count == '0
		&& !txc_ff[`UTXC_TXC_LAST];

	utxc_fifo_mem u_mem (
		.ref_clk    (ref_clk),
		.wr_en      (push),
		.wr_addr    (wr_ptr_ff[FIFO_AW-1:0]),
		.wr_data    (pwdata[7:0]),
		.rd_addr    (rd_ptr_ff[FIFO_AW-1:0]),
		.rd_data_ff (fifo_q)
	);

	utxc_crc16 u_crc (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.clear   (state_ff == UTXC_PID),
		.update  (advance),
		.data    (fifo_q),
		.crc_ff  (crc)
	);

	// Transmit sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			UTXC_IDLE: begin
				if (in_token && !do_refill && !do_flush) begin
					if (epc_ff[`UTXC_EPC_STALL] || (!is_iso && !send_ok)) begin
						nxt_state = UTXC_HSK;
					end else if (send_ok) begin
						nxt_state = UTXC_PID;
					end
				end
			end
			UTXC_HSK: begin
				if (tx_ready) begin
					nxt_state = UTXC_IDLE;
				end
			end
			UTXC_PID: begin
				if (tx_ready) begin
					nxt_state = UTXC_DATA;
				end
			end
			UTXC_DATA: begin
				if (!data_rdy_ff && count == '0) begin
					if (txc_ff[`UTXC_TXC_LAST]) begin
						nxt_state = UTXC_CRC_LO;
					end else begin
						nxt_state = UTXC_ABORT;
					end
				end
			end
			UTXC_CRC_LO: begin
				if (tx_ready) begin
					nxt_state = UTXC_CRC_HI;
				end
			end
			UTXC_CRC_HI: begin
				if (tx_ready) begin
					nxt_state = UTXC_IDLE;
				end
			end
			UTXC_ABORT: begin
				if (tx_ready) begin
					nxt_state = UTXC_IDLE;
				end
			end
			default: nxt_state = UTXC_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_ff <= UTXC_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Handshake chosen when the token is turned down
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hsk_pid_ff <= `UTXC_PID_NAK;
		end else if (idle && in_token) begin
			hsk_pid_ff <= epc_ff[`UTXC_EPC_STALL] ? `UTXC_PID_STALL
				: `UTXC_PID_NAK;
		end
	end

	// One-cycle bubble after each pointer move for the memory read
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			data_rdy_ff <= 1'b0;
		end else begin
			data_rdy_ff <= state_ff == UTXC_DATA && count != '0 && !advance;
		end
	end

	always_comb begin
		tx_valid     = state_ff != UTXC_IDLE && state_ff != UTXC_DATA;
		tx_data      = '0;
		tx_eop       = 1'b0;
		tx_stuff_err = 1'b0;
		case (state_ff)
			UTXC_HSK: begin
				tx_data = hsk_pid_ff;
				tx_eop  = 1'b1;
			end
			UTXC_PID: begin
				if (!is_iso && txc_ff[`UTXC_TXC_TOGGLE]) begin
					tx_data = `UTXC_PID_DATA1;
				end else begin
					tx_data = `UTXC_PID_DATA0;
				end
			end
			UTXC_DATA: begin
				tx_valid = data_rdy_ff;
				tx_data  = fifo_q;
			end
			UTXC_CRC_LO: tx_data = ~crc[7:0];
			UTXC_CRC_HI: begin
				tx_data = ~crc[15:8];
				tx_eop  = 1'b1;
			end
			UTXC_ABORT: begin
				tx_stuff_err = 1'b1;
				tx_eop       = 1'b1;
			end
			default: tx_data = '0;
		endcase
	end

	// FIFO pointers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wr_ptr_ff <= '0;
		end else if (do_flush || iso_drop) begin
			wr_ptr_ff <= '0;
		end else if (push) begin
			wr_ptr_ff <= wr_ptr_ff + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rd_ptr_ff <= '0;
		end else if (do_flush || iso_drop) begin
			rd_ptr_ff <= '0;
		end else if (do_refill) begin
			rd_ptr_ff <= save_ptr_ff;
		end else if (advance) begin
			rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			save_ptr_ff <= '0;
		end else if (apb_wr && hit_txc && pwdata[`UTXC_TXC_LAST]) begin
			save_ptr_ff <= rd_ptr_ff;
		end
	end

	// Control register: firmware write overrides a hardware clear
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			txc_ff <= `UTXC_TXC_RESET;
		end else if (apb_wr && hit_txc) begin
			txc_ff <= pwdata[7:0];
		end else begin
			if (pkt_end) begin
				txc_ff[`UTXC_TXC_LAST] <= 1'b0;
			end
			if (pkt_end || stall_sent || state_ff == UTXC_ABORT && tx_ready
				|| iso_drop) begin
				txc_ff[`UTXC_TXC_ARM] <= 1'b0;
			end
			if (do_refill) begin
				txc_ff[`UTXC_TXC_RFF] <= 1'b0;
			end
			if (do_flush) begin
				txc_ff[`UTXC_TXC_FLUSH] <= 1'b0;
				txc_ff[`UTXC_TXC_ARM]   <= 1'b0;
				txc_ff[`UTXC_TXC_LAST]  <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			epc_ff <= `UTXC_EPC_RESET;
		end else if (apb_wr && hit_epc) begin
			epc_ff <= pwdata[7:0];
		end
	end

	// Remembers a matching frame in which no token arrived
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			iso_seen_ff <= 1'b0;
		end else if (sof_seen || !idle) begin
			iso_seen_ff <= 1'b0;
		end else if (is_iso && send_ok) begin
			iso_seen_ff <= 1'b1;
		end
	end

	// Sticky flags: a set in the read cycle wins over the clear
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			warn_ev_ff <= 1'b0;
		end else if (warn_now) begin
			warn_ev_ff <= 1'b1;
		end else if (apb_rd && hit_fifo_warning_event_register) begin
			warn_ev_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			urun_ff <= 1'b0;
		end else if (urun_set) begin
			urun_ff <= 1'b1;
		end else if (apb_rd && hit_txs) begin
			urun_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			done_ff <= 1'b0;
		end else if (pkt_end || stall_sent || iso_drop) begin
			done_ff <= 1'b1;
		end else if (apb_rd && hit_txs) begin
			done_ff <= 1'b0;
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			prdata_ff <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata_ff <= '0;
			if (hit_txs) begin
				prdata_ff[`UTXC_TXS_URUN] <= urun_ff;
				prdata_ff[`UTXC_TXS_DONE] <= done_ff;
				prdata_ff[4:0] <= 5'((7'h40 - count) > `UTXC_EMPTY_CAP
					? `UTXC_EMPTY_CAP : 7'h40 - count);
			end else if (hit_txc) begin
				prdata_ff[7:0] <= txc_ff;
			end else if (hit_epc) begin
				prdata_ff[7:0] <= epc_ff;
			end else if (hit_fifo_warning_event_register) begin
				prdata_ff[`UTXC_FIFO_WARNING_EVENT_REGISTER_WARN] <= warn_ev_ff;
			end
		end
	end
endmodule

// ---- utxc_tx_endpoint_props.sv ----
// Port checker for the transmit endpoint control block.
// Assumes binding to utxc_tx_endpoint; sees only its ports.
`timescale 1ns/1ns
`include "utxc_cfg.svh"

module utxc_tx_endpoint_props (
	input wire logic                 ref_clk,
	input wire logic                 reset_n,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [31:0]          paddr,
	input wire logic [31:0]          prdata,
	input wire logic                 pslverr,
	input wire logic                 in_token,
	input wire logic                 tx_ready,
	input wire logic                 tx_valid,
	input wire utxc_pkg::utxc_byte_t tx_data,
	input wire logic                 tx_eop,
	input wire logic                 tx_stuff_err
);
	import utxc_pkg::*;
	logic in_pkt_ff;
	logic mapped;
	assign mapped = paddr inside {`UTXC_IDX_TXD << 2, `UTXC_IDX_TXS << 2,
		`UTXC_IDX_TXC << 2, `UTXC_IDX_EPC << 2, `UTXC_IDX_FIFO_WARNING_EVENT_REGISTER << 2};
	// Inside a packet once its first item is taken
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			in_pkt_ff <= 1'b0;
		else if (tx_valid && tx_ready)
			in_pkt_ff <= !tx_eop;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_slverr_decode: assert property (psel && penable |-> pslverr == !mapped)
		else $error("slave error does not match decode");
	a_unmapped_zero: assert property (psel && !penable && !pwrite && !mapped
		|=> prdata == 32'h0) else $error("unmapped read not zero");
	a_item_hold: assert property (tx_valid && !tx_ready |=> tx_valid &&
		$stable(tx_data) && $stable(tx_eop)) else $error("item dropped");
	a_stuff_eop: assert property (tx_stuff_err |-> tx_valid && tx_eop)
		else $error("stuff error without end");
	a_eop_idle: assert property (tx_valid && tx_ready && tx_eop
		|=> !tx_valid) else $error("item after packet end");
	a_pid_token: assert property ($rose(tx_valid) && !in_pkt_ff
		|-> $past(in_token)) else $error("packet without token");
	a_pid_code: assert property (tx_valid && !in_pkt_ff |-> tx_data inside
		{8'hc3, 8'h4b, 8'h5a, 8'h1e}) else $error("bad first item");
	a_crc_follows: assert property (tx_valid && !in_pkt_ff &&
		tx_data inside {8'hc3, 8'h4b} |-> !tx_eop) else $error("pid ends");
	a_reset_quiet: assert property (disable iff (1'b0) !reset_n
		|=> !tx_valid && prdata == 32'h0) else $error("busy after reset");
	c_packet: cover property (tx_valid && tx_ready && tx_eop && !tx_stuff_err);
	c_underrun: cover property (tx_valid && tx_ready && tx_stuff_err);
	c_slverr: cover property (psel && penable && pslverr);
endmodule

bind utxc_tx_endpoint utxc_tx_endpoint_props u_props (.ref_clk(ref_clk),
	.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pslverr(pslverr), .in_token(in_token),
	.tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
	.tx_eop(tx_eop), .tx_stuff_err(tx_stuff_err));

// ---- utxc_host.sv ----
// Host and serial engine model facing the transmit endpoint.
// Assumes the same clock as the endpoint; tasks are called by tb.
`timescale 1ns/1ns

module utxc_host (
	input wire logic                 ref_clk,
	input wire logic                 tx_valid,
	input wire utxc_pkg::utxc_byte_t tx_data,
	input wire logic                 tx_eop,
	input wire logic                 tx_stuff_err,
	output logic                     in_token,
	output logic                     sof_seen,
	output logic                     frame_number_lsb,
	output logic                     tx_ready
);
	import utxc_pkg::*;
	logic       slow = 1'b0;
	logic [9:0] got[$];
	initial begin
		in_token = 1'b0;
		sof_seen = 1'b0;
		frame_number_lsb = 1'b0;
		tx_ready = 1'b1;
	end
	// Record taken items; slow mode takes every other cycle
	always @(posedge ref_clk) begin
		if (tx_valid && tx_ready)
			got.push_back({tx_stuff_err, tx_eop, tx_data});
		tx_ready <= !slow || !tx_ready;
	end
	task token();
		@(posedge ref_clk);
		in_token <= 1'b1;
		@(posedge ref_clk);
		in_token <= 1'b0;
	endtask
	// Start of frame carries the new frame number
	task frame(input logic lsb);
		@(posedge ref_clk);
		sof_seen <= 1'b1;
		frame_number_lsb <= lsb;
		@(posedge ref_clk);
		sof_seen <= 1'b0;
	endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the transmit endpoint control block.
// Assumes the host model stands on the serial side.
`timescale 1ns/1ns
`include "utxc_cfg.svh"

module tb;
	import utxc_pkg::*;
	logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
	logic pready, pslverr, se, in_token, sof_seen, frame_number_lsb;
	logic tx_ready, tx_valid, tx_eop, tx_stuff_err;
	utxc_byte_t tx_data;
	int err_total = 0, checks_done = 0, cyc = 0;
	localparam logic [31:0] DAT = `UTXC_IDX_TXD, STS = `UTXC_IDX_TXS;
	localparam logic [31:0] CTL = `UTXC_IDX_TXC, EPC = `UTXC_IDX_EPC;
	localparam logic [31:0] EVT = `UTXC_IDX_FIFO_WARNING_EVENT_REGISTER;
	utxc_tx_endpoint u_utxc_tx_endpoint (.ref_clk, .reset_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.in_token, .sof_seen, .frame_number_lsb, .tx_ready, .tx_valid,
		.tx_data, .tx_eop, .tx_stuff_err);
	utxc_host u_utxc_host (.ref_clk, .tx_valid, .tx_data, .tx_eop,
		.tx_stuff_err, .in_token, .sof_seen, .frame_number_lsb, .tx_ready);
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task tally_and_finish();
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] g);
		checks_done++;
		if (g !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, g);
		end
	endtask
	task apb(input logic w, input logic [31:0] idx, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= idx << 2;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [31:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask
	task rchk(input logic [31:0] idx, input string w, input logic [31:0] e);
		apb(1'b0, idx, 32'h0);
		chk(w, e, rd & 32'hff);
	endtask
	task fill(input int n, input logic [7:0] b0);
		for (int i = 0; i < n; i++)
			wr(DAT, {24'h0, b0 + 8'(i)});
	endtask
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int j = 0; j < 8; j++)
			r = (r >> 1) ^ ((r[0] ^ b[j]) ? `UTXC_CRC_POLY : 16'h0);
		return r;
	endfunction
	task pkt(input int n, input logic [7:0] pid, input logic [7:0] b0,
		input logic st);
		int k;
		logic [15:0] c;
		u_utxc_host.got.delete();
		u_utxc_host.token();
		k = 0;
		while (k < 300 && !(u_utxc_host.got.size() > 0 &&
			u_utxc_host.got[$][8])) begin
			@(posedge ref_clk);
			k++;
		end
		chk("items", n + 3 - st, u_utxc_host.got.size());
		chk("pid", {24'h0, pid}, {22'h0, u_utxc_host.got[0]});
		for (int i = 0; i < n; i++)
			chk("payload", b0 + i, {22'h0, u_utxc_host.got[i + 1]});
		chk("end", {st, 1'b1}, u_utxc_host.got[$] >> 8);
		c = `UTXC_CRC_INIT;
		for (int i = 0; i < n; i++)
			c = crc_step(c, b0 + 8'(i));
		if (!st) begin
			chk("crc lo", {24'h0, ~c[7:0]},
				{22'h0, u_utxc_host.got[n + 1]});
			chk("crc hi", {24'h1, ~c[15:8]},
				{22'h0, u_utxc_host.got[n + 2]});
		end
	endtask
	task t_packets();
		rchk(CTL, "control reset", 32'h0);
		rchk(STS, "status reset", 32'h1f);
		for (int t = 0; t < 2; t++) begin
			fill(3, 8'h10);
			wr(CTL, 32'h3 | (t << 2));
			pkt(3, t ? 8'h4b : 8'hc3, 8'h10, 1'b0);
			rchk(CTL, "control", t << 2);
			rchk(STS, "status", 32'h3f);
		end
		wr(CTL, 32'h10);
		rchk(CTL, "refill cleared", 32'h0);
		u_utxc_host.slow <= 1'b1;
		wr(CTL, 32'h7);
		pkt(3, 8'h4b, 8'h10, 1'b0);
		u_utxc_host.slow <= 1'b0;
		wr(CTL, 32'h3);
		pkt(0, 8'hc3, 8'h0, 1'b0);
		fill(1, 8'h55);
		wr(CTL, 32'h1);
		pkt(1, 8'hc3, 8'h55, 1'b1);
		rchk(STS, "underrun", 32'hbf);
		rchk(STS, "underrun clear", 32'h1f);
		rchk(CTL, "arm after underrun", 32'h0);
	endtask
	task t_iso();
		wr(EPC, 32'h20);
		fill(2, 8'h30);
		wr(CTL, 32'h7);
		u_utxc_host.got.delete();
		u_utxc_host.token();
		repeat (20) @(posedge ref_clk);
		chk("iso parity", 0, u_utxc_host.got.size());
		u_utxc_host.frame(1'b1);
		pkt(2, 8'hc3, 8'h30, 1'b0);
		rchk(STS, "iso sent", 32'h3f);
		fill(2, 8'h40);
		wr(CTL, 32'h3);
		u_utxc_host.frame(1'b0);
		u_utxc_host.frame(1'b1);
		repeat (4) @(posedge ref_clk);
		rchk(STS, "iso flush", 32'h3f);
		rchk(CTL, "iso control", 32'h2);
		wr(CTL, 32'h7);
		pkt(0, 8'hc3, 8'h0, 1'b0);
		fill(1, 8'h66);
		wr(CTL, 32'h83);
		pkt(1, 8'hc3, 8'h66, 1'b0);
		rchk(STS, "iso sent again", 32'h3f);
		wr(EPC, 32'h0);
	endtask
	task t_warn();
		int lim;
		for (int c = 1; c < 4; c++) begin
			lim = c == 1 ? 5 : (c == 2 ? 9 : 17);
			wr(CTL, 32'h8);
			rchk(STS, "flushed", 32'h1f);
			rchk(EVT, "warn idle", 32'h0);
			fill(lim - 1, 8'h0);
			wr(CTL, c << 5);
			rchk(EVT, "warn unarmed", 32'h0);
			wr(CTL, (c << 5) | 1);
			rchk(EVT, "warn low", 32'h1);
			wr(CTL, 32'h8);
			rchk(EVT, "warn sticky", 32'h1);
			rchk(EVT, "warn cleared", 32'h0);
			fill(lim, 8'h0);
			wr(CTL, (c << 5) | 1);
			rchk(EVT, "warn above", 32'h0);
		end
		wr(CTL, 32'h8);
		fill(1, 8'h0);
		wr(CTL, 32'h1);
		rchk(EVT, "warn off", 32'h0);
		wr(CTL, 32'h8);
	endtask
	task t_hsk();
		u_utxc_host.got.delete();
		u_utxc_host.token();
		repeat (6) @(posedge ref_clk);
		chk("nak items", 1, u_utxc_host.got.size());
		chk("nak", 32'h15a, {22'h0, u_utxc_host.got[0]});
		wr(EPC, 32'h80);
		wr(CTL, 32'h1);
		u_utxc_host.got.delete();
		u_utxc_host.token();
		repeat (6) @(posedge ref_clk);
		chk("stall", 32'h11e, {22'h0, u_utxc_host.got[0]});
		rchk(CTL, "arm after stall", 32'h0);
		rchk(STS, "stall done", 32'h3f);
		wr(EPC, 32'h0);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_packets();
		t_iso();
		t_warn();
		t_hsk();
		apb(1'b1, 32'h50001870, 32'hff);
		chk("slverr", 1, se);
		apb(1'b0, 32'h50001870, 32'h0);
		chk("unmapped read", 0, rd);
		chk("slverr read", 1, se);
		tally_and_finish();
	end
endmodule
